// [verilog/abz_defines.svh]
`ifndef ABZ_DEFINES_SVH
`define ABZ_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define ABZ_OFF_CTRL 8'h00
`define ABZ_OFF_MUX 8'h04
`define ABZ_OFF_STATUS 8'h08
`define ABZ_OFF_RESULT 8'h0c

// ==========================================================
// Control register fields
`define ABZ_CTRL_CS_LO 0
`define ABZ_CTRL_CS_HI 1
`define ABZ_CTRL_AZ 2
`define ABZ_CTRL_MODE_LO 3
`define ABZ_CTRL_MODE_HI 4
`define ABZ_CTRL_CRST 5
`define ABZ_CTRL_SHDN 6
`define ABZ_CTRL_START 7

// ==========================================================
// Input selection register fields
`define ABZ_MUX_POS_HI 7
`define ABZ_MUX_POS_LO 4
`define ABZ_MUX_NEG_HI 3
`define ABZ_MUX_NEG_LO 0
`define ABZ_MUX_SCAN_TEMP 8

// ==========================================================
// Status register fields
`define ABZ_STAT_BUSY 0
`define ABZ_STAT_READY 1
`define ABZ_STAT_BIAS 2
`define ABZ_STAT_PHASE 3

// ==========================================================
// Result register field
`define ABZ_RES_HI 15
`define ABZ_RES_LO 0

// ==========================================================
// Codes and reset values
`define ABZ_TEMP_SEL 8'hde
`define ABZ_MODE_CONT 2'b11
`define ABZ_BIAS_OFF 2'b00
`define ABZ_RESP_OKAY 2'b00
`define ABZ_RESP_SLVERR 2'b10
`define ABZ_MUX_RST 8'h01
`define ABZ_MODE_RST 2'b00
`define ABZ_CS_RST 2'b00

`endif

// [verilog/abz_pkg.sv]
package abz_pkg;

    typedef enum logic [1:0] {ABZ_IDLE, ABZ_FIRST, ABZ_SECOND} abz_state_e;

    typedef struct packed {
        logic start;
        logic filt_reset;
        logic continuous;
        logic [3:0] pos_sel;
        logic [3:0] neg_sel;
    } abz_conv_s;

    typedef struct packed {
        logic [1:0] code;
        logic source_en;
        logic sink_en;
        logic temp_bias_en;
    } abz_bias_s;

endpackage : abz_pkg

// [verilog/abz_bias_dec.sv]
`timescale 1ns/10ps
`include "abz_defines.svh"

module abz_bias_dec (
    input wire logic [1:0] cs_sel,
    input wire logic [7:0] mux,
    input wire logic scan_temp,
    output abz_pkg::abz_bias_s bias
);
    import abz_pkg::*;

    logic temp_on;

    // ======================================================
    // Temperature path override
    // diodes replace burnout
    assign temp_on = (mux == `ABZ_TEMP_SEL) || scan_temp;

    always_comb
    begin
        bias.code = temp_on ? `ABZ_BIAS_OFF : cs_sel;
        bias.source_en = (bias.code != `ABZ_BIAS_OFF);
        bias.sink_en = (bias.code != `ABZ_BIAS_OFF);
        bias.temp_bias_en = temp_on;
    end

endmodule : abz_bias_dec

// [verilog/abz_half_diff.sv]
`timescale 1ns/10ps

module abz_half_diff (
    input wire logic [15:0] first,
    input wire logic [15:0] second,
    output logic [15:0] half
);
    logic [16:0] diff;

    // ======================================================
    // Halved difference
    // sign extend, drop lsb
    assign diff = {first[15], first} - {second[15], second};
    assign half = diff[16:1];

endmodule : abz_half_diff

// [verilog/abz_ctrl.sv]
`timescale 1ns/10ps
`include "abz_defines.svh"


module abz_ctrl (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    output logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    input wire logic CONV_DONE,
    input wire logic [15:0] CONV_DATA,
    output abz_pkg::abz_conv_s CONV,
    output abz_pkg::abz_bias_s BIAS,
    output logic RESULT_DONE
);
    import abz_pkg::*;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_got;
        logic w_got;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [1:0] cs_sel;
        logic az_en;
        logic [1:0] mode;
        logic conv_rst;
        logic shdn;
        logic [7:0] mux;
        logic scan_temp;
        abz_state_e state;
        logic run_az;
        logic [3:0] run_pos;
        logic [3:0] run_neg;
        logic [15:0] partial;
        logic [15:0] result;
        logic ready;
        logic done;
        abz_conv_s conv;
        abz_bias_s bias;
    } abz_top_s;

    abz_top_s s;
    abz_top_s next_s;
    abz_bias_s bias_w;
    logic [15:0] half_w;

    // ======================================================
    // Helpers
    // decode never looks at the sequencer
    abz_bias_dec u_bias (
        .cs_sel(s.cs_sel),
        .mux(s.mux),
        .scan_temp(s.scan_temp),
        .bias(bias_w)
    );

    abz_half_diff u_half (
        .first(s.partial),
        .second(CONV_DATA),
        .half(half_w)
    );

    // ======================================================
    // Next state
    always_comb
    begin
        logic aw_hs;
        logic w_hs;
        logic ar_hs;
        logic start_req;
        logic rd_clr;
        logic set_rdy;
        logic go_cont;
        aw_hs = S_AXI_AWVALID && s.awready;
        w_hs = S_AXI_WVALID && s.wready;
        ar_hs = S_AXI_ARVALID && s.arready;
        start_req = 1'b0;
        rd_clr = 1'b0;
        set_rdy = 1'b0;
        go_cont = (s.mode == `ABZ_MODE_CONT);
        next_s = s;
        next_s.done = 1'b0;
        next_s.conv.start = 1'b0;
        next_s.conv.filt_reset = 1'b0;

        // ==================================================
        // Write channel
        if (s.bvalid && S_AXI_BREADY)
        begin
            next_s.bvalid = 1'b0;
        end
        if (aw_hs)
        begin
            next_s.aw_got = 1'b1;
            next_s.waddr = S_AXI_AWADDR;
        end
        if (w_hs)
        begin
            next_s.w_got = 1'b1;
            next_s.wdata = S_AXI_WDATA;
            next_s.wstrb = S_AXI_WSTRB;
        end
        if (next_s.aw_got && next_s.w_got)
        begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = `ABZ_RESP_OKAY;
            case (next_s.waddr)
                `ABZ_OFF_CTRL:
                begin
                    if (next_s.wstrb[0])
                    begin
                        next_s.cs_sel = next_s.wdata[`ABZ_CTRL_CS_HI:
                                                     `ABZ_CTRL_CS_LO];
                        next_s.az_en = next_s.wdata[`ABZ_CTRL_AZ];
                        next_s.mode = next_s.wdata[`ABZ_CTRL_MODE_HI:
                                                   `ABZ_CTRL_MODE_LO];
                        next_s.conv_rst = next_s.wdata[`ABZ_CTRL_CRST];
                        next_s.shdn = next_s.wdata[`ABZ_CTRL_SHDN];
                        start_req = next_s.wdata[`ABZ_CTRL_START];
                    end
                end
                `ABZ_OFF_MUX:
                begin
                    if (next_s.wstrb[0])
                    begin
                        next_s.mux = next_s.wdata[`ABZ_MUX_POS_HI:
                                                  `ABZ_MUX_NEG_LO];
                    end
                    if (next_s.wstrb[1])
                    begin
                        next_s.scan_temp =
                            next_s.wdata[`ABZ_MUX_SCAN_TEMP];
                    end
                end
                `ABZ_OFF_STATUS, `ABZ_OFF_RESULT:
                begin
                    // Read-only; write accepted and dropped
                    next_s.bresp = `ABZ_RESP_OKAY;
                end
                default:
                begin
                    next_s.bresp = `ABZ_RESP_SLVERR;
                end
            endcase
        end
        // Only one write in flight; response must drain first
        next_s.awready = !next_s.aw_got && !next_s.bvalid;
        next_s.wready = !next_s.w_got && !next_s.bvalid;

        // ==================================================
        // Read channel
        if (s.rvalid && S_AXI_RREADY)
        begin
            next_s.rvalid = 1'b0;
        end
        if (ar_hs)
        begin
            next_s.rvalid = 1'b1;
            next_s.rresp = `ABZ_RESP_OKAY;
            next_s.rdata = '0;
            case (S_AXI_ARADDR)
                `ABZ_OFF_CTRL:
                begin
                    next_s.rdata[`ABZ_CTRL_CS_HI:`ABZ_CTRL_CS_LO] =
                        s.cs_sel;
                    next_s.rdata[`ABZ_CTRL_AZ] = s.az_en;
                    next_s.rdata[`ABZ_CTRL_MODE_HI:`ABZ_CTRL_MODE_LO] =
                        s.mode;
                    next_s.rdata[`ABZ_CTRL_CRST] = s.conv_rst;
                    next_s.rdata[`ABZ_CTRL_SHDN] = s.shdn;
                end
                `ABZ_OFF_MUX:
                begin
                    next_s.rdata[`ABZ_MUX_POS_HI:`ABZ_MUX_NEG_LO] = s.mux;
                    next_s.rdata[`ABZ_MUX_SCAN_TEMP] = s.scan_temp;
                end
                `ABZ_OFF_STATUS:
                begin
                    next_s.rdata[`ABZ_STAT_BUSY] = (s.state != ABZ_IDLE);
                    next_s.rdata[`ABZ_STAT_READY] = s.ready;
                    next_s.rdata[`ABZ_STAT_BIAS] = s.bias.source_en;
                    next_s.rdata[`ABZ_STAT_PHASE] =
                        (s.state == ABZ_SECOND);
                end
                `ABZ_OFF_RESULT:
                begin
                    next_s.rdata[`ABZ_RES_HI:`ABZ_RES_LO] = s.result;
                    rd_clr = 1'b1;
                end
                default:
                begin
                    next_s.rresp = `ABZ_RESP_SLVERR;
                end
            endcase
        end
        next_s.arready = !next_s.rvalid;

        // ==================================================
        // Conversion sequencer
        case (s.state)
            ABZ_IDLE:
            begin
                if (start_req || go_cont)
                begin
                    next_s.state = ABZ_FIRST;
                    // Settings written with the start bit apply to this run
                    next_s.run_az = next_s.az_en;
                    next_s.run_pos =
                        next_s.mux[`ABZ_MUX_POS_HI:`ABZ_MUX_POS_LO];
                    next_s.run_neg =
                        next_s.mux[`ABZ_MUX_NEG_HI:`ABZ_MUX_NEG_LO];
                    next_s.conv.pos_sel = next_s.run_pos;
                    next_s.conv.neg_sel = next_s.run_neg;
                    next_s.conv.start = 1'b1;
                    next_s.conv.filt_reset = next_s.az_en;
                    // plain run uses the converter as is
                    next_s.conv.continuous =
                        (next_s.mode == `ABZ_MODE_CONT) && !next_s.az_en;
                end
            end
            ABZ_FIRST:
            begin
                if (CONV_DONE && s.run_az)
                begin
                    next_s.partial = CONV_DATA;
                    next_s.conv.pos_sel = s.run_neg;
                    next_s.conv.neg_sel = s.run_pos;
                    next_s.conv.start = 1'b1;
                    next_s.conv.filt_reset = 1'b1;
                    next_s.state = ABZ_SECOND;
                end
                else if (CONV_DONE)
                begin
                    next_s.result = CONV_DATA;
                    set_rdy = 1'b1;
                    next_s.done = 1'b1;
                    if (!go_cont || s.az_en)
                    begin
                        next_s.state = ABZ_IDLE;
                        next_s.conv.continuous = 1'b0;
                    end
                end
            end
            ABZ_SECOND:
            begin
                if (CONV_DONE)
                begin
                    next_s.result = half_w;
                    set_rdy = 1'b1;
                    next_s.done = 1'b1;
                    next_s.state = ABZ_IDLE;
                    if (go_cont && s.az_en)
                    begin
                        next_s.state = ABZ_FIRST;
                        next_s.run_pos =
                            s.mux[`ABZ_MUX_POS_HI:`ABZ_MUX_POS_LO];
                        next_s.run_neg =
                            s.mux[`ABZ_MUX_NEG_HI:`ABZ_MUX_NEG_LO];
                        next_s.conv.pos_sel = next_s.run_pos;
                        next_s.conv.neg_sel = next_s.run_neg;
                        next_s.conv.start = 1'b1;
                        next_s.conv.filt_reset = 1'b1;
                    end
                end
            end
            default:
            begin
                next_s.state = ABZ_IDLE;
            end
        endcase

        // Converter reset or shutdown aborts the run, not the bias
        if (s.conv_rst || s.shdn)
        begin
            next_s.state = ABZ_IDLE;
            next_s.conv.start = 1'b0;
            next_s.conv.filt_reset = 1'b0;
            next_s.conv.continuous = 1'b0;
        end

        // Set wins over the read clear
        if (rd_clr)
        begin
            next_s.ready = 1'b0;
        end
        if (set_rdy)
        begin
            next_s.ready = 1'b1;
        end

        next_s.bias = bias_w;
    end

    // ======================================================
    // State register
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            s <= '0;
            s.mux <= `ABZ_MUX_RST;
            s.mode <= `ABZ_MODE_RST;
            s.cs_sel <= `ABZ_CS_RST;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign S_AXI_AWREADY = s.awready;
    assign S_AXI_WREADY = s.wready;
    assign S_AXI_BVALID = s.bvalid;
    assign S_AXI_BRESP = s.bresp;
    assign S_AXI_ARREADY = s.arready;
    assign S_AXI_RVALID = s.rvalid;
    assign S_AXI_RDATA = s.rdata;
    assign S_AXI_RRESP = s.rresp;
    assign CONV = s.conv;
    assign BIAS = s.bias;
    assign RESULT_DONE = s.done;

    // ======================================================
    // Assertions
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    logic temp_now;
    logic [16:0] chk_diff;
    assign temp_now = (s.mux == `ABZ_TEMP_SEL) || s.scan_temp;
    assign chk_diff = {s.partial[15], s.partial} - {CONV_DATA[15],
                                                     CONV_DATA};

    bias_code_a: assert property (
        ##1 BIAS.code == ($past(temp_now) ? `ABZ_BIAS_OFF : $past(s.cs_sel)))
        else $error("bias code does not follow select");
    bias_pair_a: assert property (
        BIAS.source_en == BIAS.sink_en &&
        BIAS.source_en == (BIAS.code != `ABZ_BIAS_OFF))
        else $error("source and sink disagree");
    bias_hold_a: assert property (
        (s.conv_rst || s.shdn) && !temp_now &&
        s.cs_sel != `ABZ_BIAS_OFF |=> BIAS.source_en)
        else $error("bias dropped in reset or shutdown");
    temp_route_a: assert property (
        temp_now |=> BIAS.temp_bias_en && !BIAS.source_en)
        else $error("temperature selection left burnout on");
    nibble_map_a: assert property (
        CONV.start && s.state == ABZ_FIRST |->
        {CONV.pos_sel, CONV.neg_sel} == {s.run_pos, s.run_neg})
        else $error("first half input mapping wrong");
    swap_half_a: assert property (
        CONV.start && s.state == ABZ_SECOND |->
        CONV.pos_sel == s.run_neg && CONV.neg_sel == s.run_pos)
        else $error("second half not swapped");
    plain_pass_a: assert property (
        s.state == ABZ_FIRST && CONV_DONE && !s.run_az &&
        !s.conv_rst && !s.shdn |=> s.result == $past(CONV_DATA) &&
        RESULT_DONE)
        else $error("plain result not passed through");
    half_diff_a: assert property (
        s.state == ABZ_SECOND && CONV_DONE && !s.conv_rst && !s.shdn
        |=> s.result == $past(chk_diff[16:1]) && RESULT_DONE)
        else $error("combined result wrong");
    first_quiet_a: assert property (
        s.state == ABZ_FIRST && CONV_DONE && s.run_az |=> !RESULT_DONE)
        else $error("completion flagged on first half");
    az_cont_a: assert property (
        s.state == ABZ_SECOND && CONV_DONE && s.az_en && !s.conv_rst &&
        !s.shdn && s.mode == `ABZ_MODE_CONT |=>
        CONV.start && CONV.filt_reset && s.state == ABZ_FIRST)
        else $error("continuous pair not restarted at once");

    cv_plain: cover property (s.state == ABZ_FIRST && CONV_DONE &&
                              !s.run_az);
    cv_pair: cover property (s.state == ABZ_SECOND && CONV_DONE);
    cv_temp: cover property (temp_now && s.cs_sel != `ABZ_BIAS_OFF);
    cv_cont: cover property (CONV.start && s.state == ABZ_SECOND ##[1:50]
                             CONV.start && s.state == ABZ_FIRST);

endmodule : abz_ctrl

// [bench/abz_conv_model.sv]
`timescale 1ns/10ps
// ==============================
// Converter stand-in
module abz_conv_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [4:0] lat,
    input wire abz_pkg::abz_conv_s conv,
    output logic done,
    output logic [15:0] data
);
    import abz_pkg::*;
    logic [4:0] cnt;
    logic [15:0] val;
    // Data flips outside the done cycle, so a late read is caught
    always @(posedge clk)
    begin
        done <= 1'h0;
        data <= ~data;
        if (rst)
        begin
            cnt <= 5'h00;
            data <= 16'ha5a5;
        end
        else if (conv.start)
        begin
            cnt <= lat;
            val <= {conv.pos_sel, conv.neg_sel, 8'h5a};
        end
        else if (cnt == 5'h01)
        begin
            cnt <= conv.continuous ? lat : 5'h00;
            done <= 1'h1;
            data <= val;
        end
        else if (cnt != 5'h00)
            cnt <= cnt - 5'h01;
    end
endmodule : abz_conv_model

// [bench/abz_ctrl_tb.sv]
`timescale 1ns/10ps
`include "abz_defines.svh"
// ==============================
// Bench: burnout, temperature override, offset cancel
module abz_ctrl_tb;
    import abz_pkg::*;
    logic CORE_CLK = 1'h0;
    logic RST = 1'h1;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, done, res_done;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp, resp;
    logic [15:0] cdata;
    logic [4:0] lat = 5'h03;
    abz_conv_s conv;
    abz_bias_s bias;
    int num_errors = 0, comparisons = 0, t1 = 0;
    int starts = 0, resets = 0, n_res = 0, gapless = 0, cycles = 0;
    logic [7:0] sel_q[$];

    always #50 CORE_CLK = ~CORE_CLK;

    abz_ctrl dut (
        .CORE_CLK(CORE_CLK), .RST(RST),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_AWADDR(awaddr), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .CONV_DONE(done), .CONV_DATA(cdata), .CONV(conv), .BIAS(bias),
        .RESULT_DONE(res_done)
    );

    abz_conv_model model (
        .clk(CORE_CLK), .rst(RST), .lat(lat), .conv(conv),
        .done(done), .data(cdata)
    );

    // ==============================
    // Monitor and watchdog
    always @(posedge CORE_CLK)
    begin
        cycles++;
        if (conv.start === 1'h1)
        begin
            starts++;
            sel_q.push_back({conv.pos_sel, conv.neg_sel});
            if (conv.filt_reset === 1'h1)
                resets++;
            if (res_done === 1'h1)
                gapless++;
        end
        if (res_done === 1'h1)
            n_res++;
        // Whole run needs well under a thousand cycles
        if (cycles == 5000)
        begin
            num_errors++;
            results();
        end
    end

    // ==============================
    // Shared tasks
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CORE_CLK);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(posedge CORE_CLK);
            if (awready === 1'h1)
                awvalid <= 1'h0;
            if (wready === 1'h1)
                wvalid <= 1'h0;
        end
        while (bvalid !== 1'h1);
        bready <= 1'h0;
        resp = bresp;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge CORE_CLK);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(posedge CORE_CLK);
            if (arready === 1'h1)
                arvalid <= 1'h0;
        end
        while (rvalid !== 1'h1);
        rready <= 1'h0;
        resp = rresp;
    endtask : rd

    task automatic wait_res(output int n);
        n = 0;
        do
        begin
            @(posedge CORE_CLK);
            n++;
        end
        while (res_done !== 1'h1 && n < 300);
        check("result done", res_done, 1'h1);
    endtask : wait_res

    // ==============================
    // Scenarios
    task automatic t_reset();
        check("bias", bias, 5'h00);
        rd(`ABZ_OFF_CTRL);
        check("ctrl", rdata, 32'h0);
        rd(`ABZ_OFF_MUX);
        check("mux", rdata, 32'h1);
        rd(8'h10);
        check("rd resp", resp, 2'h2);
        check("rd data", rdata, 32'h0);
        wr(8'h20, 32'h3);
        check("wr resp", resp, 2'h2);
        $display("test reset done");
    endtask : t_reset

    task automatic t_burnout();
        logic [1:0] c;
        int s;
        s = starts;
        for (int i = 0; i < 4; i++)
        begin
            c = i[1:0];
            // Converter reset or shutdown held while the code changes
            wr(`ABZ_OFF_CTRL, {24'h0, 1'h0, ~c[0], c[0], 3'h0, c});
            rd(`ABZ_OFF_STATUS);
            check("bias", bias, {c, c != 2'h0, c != 2'h0, 1'h0});
            check("bias on", rdata[2], c != 2'h0);
        end
        check("no start", starts, s);
        wr(`ABZ_OFF_CTRL, 32'h2);
        $display("test burnout done");
    endtask : t_burnout

    task automatic t_temp();
        int n;
        wr(`ABZ_OFF_MUX, 32'hde);
        wr(`ABZ_OFF_CTRL, 32'h82);
        wait_res(n);
        check("temp bias", bias, 5'h01);
        check("temp sel", sel_q[$], 8'hde);
        rd(`ABZ_OFF_CTRL);
        check("select kept", rdata[1:0], 2'h2);
        wr(`ABZ_OFF_MUX, 32'h112);
        rd(`ABZ_OFF_STATUS);
        check("scan bias", bias, 5'h01);
        wr(`ABZ_OFF_MUX, 32'h12);
        rd(`ABZ_OFF_STATUS);
        check("bias back", bias, 5'h16);
        $display("test temperature done");
    endtask : t_temp

    task automatic t_plain();
        int s;
        s = starts;
        lat <= 5'h08;
        wr(`ABZ_OFF_CTRL, 32'h80);
        wait_res(t1);
        rd(`ABZ_OFF_RESULT);
        check("plain value", rdata[15:0], 16'h125a);
        check("plain starts", starts - s, 1);
        check("plain sel", sel_q[$], 8'h12);
        $display("test plain done");
    endtask : t_plain

    task automatic t_cancel();
        int s, r, t2;
        logic [16:0] d;
        wr(`ABZ_OFF_MUX, 32'h78);
        s = starts;
        r = n_res;
        wr(`ABZ_OFF_CTRL, 32'h84);
        wait_res(t2);
        rd(`ABZ_OFF_RESULT);
        // Difference overflows 16 bits, so the 17th bit matters
        d = {1'h0, 16'h785a} - {1'h1, 16'h875a};
        check("az value", rdata[15:0], d[16:1]);
        check("az starts", starts - s, 2);
        check("az results", n_res - r, 1);
        check("first sel", sel_q[$-1], 8'h78);
        check("second sel", sel_q[$], 8'h87);
        check("az time", t2 > 16 && t2 <= 2 * t1, 1);
        $display("test cancel done");
    endtask : t_cancel

    task automatic t_cont();
        int s, r, g, f, n;
        lat <= 5'h02;
        s = starts;
        r = n_res;
        g = gapless;
        f = resets;
        wr(`ABZ_OFF_CTRL, 32'h9c);
        repeat (3) wait_res(n);
        wr(`ABZ_OFF_CTRL, 32'h04);
        rd(`ABZ_OFF_STATUS);
        for (int i = 0; i < 20 && rdata[0] !== 1'h0; i++)
            rd(`ABZ_OFF_STATUS);
        check("idle", rdata[0], 1'h0);
        check("many results", n_res - r >= 3, 1);
        check("pair rate", starts - s, 2 * (n_res - r));
        check("filter resets", resets - f, starts - s);
        check("no gap", gapless - g, n_res - r - 1);
        rd(`ABZ_OFF_RESULT);
        check("cont value", rdata[15:0], 16'h7880);
        $display("test continuous done");
    endtask : t_cont

    task automatic t_abort();
        int s, n;
        s = starts;
        // Plain continuous run, then a converter reset cuts it
        wr(`ABZ_OFF_CTRL, 32'h98);
        wait_res(n);
        wait_res(n);
        check("cont level", conv.continuous, 1'h1);
        check("one start", starts - s, 1);
        rd(`ABZ_OFF_STATUS);
        check("busy ready", rdata[1:0], 2'h3);
        wr(`ABZ_OFF_CTRL, 32'h38);
        rd(`ABZ_OFF_STATUS);
        check("aborted", {rdata[0], conv.continuous}, 2'h0);
        wr(`ABZ_OFF_CTRL, 32'h0);
        $display("test abort done");
    endtask : t_abort

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    initial
    begin
        repeat (5) @(posedge CORE_CLK);
        RST <= 1'h0;
        repeat (2) @(posedge CORE_CLK);
        t_reset();
        t_burnout();
        t_temp();
        t_plain();
        t_cancel();
        t_cont();
        t_abort();
        results();
    end
endmodule : abz_ctrl_tb
